// [rtl/iodu_pkg.sv]
// Package for the I/O instruction and drum unit: opcodes, fields, register map.
// Assumes a 24-bit word machine whose core memory is reached over a simple
// request/grant port owned by the surrounding processor.
package iodu_pkg;
   // -------------------------------------------------------------------------
   // Word and field layout
   // -------------------------------------------------------------------------
   localparam int WORD_W = 24;
   localparam int ADDR_W = 12;
   localparam int NGRP = 8;
   localparam int CNT_LSB = 12;
   localparam int TRK_LO_LSB = 7;
   localparam int TRK_HI_A = 13;
   localparam int TRK_HI_B = 16;
   localparam int BUF_TRK_BIT = 14;
   localparam int RAND_SEC_BIT = 15;
   localparam int SEC_W = 7;
   localparam int TRK_W = 8;
   localparam int NUM_MAIN_TRACKS = 256;
   localparam int NUM_BUF_TRACKS = 16;
   localparam int SECTORS = 128;
   // -------------------------------------------------------------------------
   // Opcodes (octal; 6-bit group opcodes over a 3-bit group field, 9-bit drum opcodes)
   // -------------------------------------------------------------------------
   localparam logic [5:0] OP_SETUP = 6'o60;
   localparam logic [5:0] OP_STORE = 6'o61;
   localparam logic [5:0] OP_LOAD = 6'o62;
   localparam logic [5:0] OP_SENSE = 6'o63;
   localparam logic [8:0] OP_DRUM_WR = 9'o440;
   localparam logic [8:0] OP_DRUM_RD = 9'o441;
   // -------------------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------------------
   localparam int CLK_MHZ = 25;
   localparam int RAND_START_US = 128;
   localparam int RAND_START_CYC = RAND_START_US * CLK_MHZ;
   // -------------------------------------------------------------------------
   // APB register map (byte addresses)
   // -------------------------------------------------------------------------
   localparam logic [7:0] REG_INSTR = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_LEFT_ACC = 8'h08;
   localparam logic [7:0] REG_DRUM_POS = 8'h0C;
   localparam logic [7:0] REG_FULL = 8'h10;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;

   typedef struct packed {
      logic [8:0] opcode;
      logic index_tag;
      logic [ADDR_W-1:0] operand;
   } iodu_instr_t;

   typedef struct packed {
      logic buffer_area;
      logic [TRK_W-1:0] track;
      logic [SEC_W-1:0] sector;
   } iodu_drum_pos_t;
endpackage

// [rtl/iodu_core.sv]
// I/O instruction unit: sense, device setup, buffer register load/store, drum.
// Assumes core memory answers mem_req with mem_gnt (read data valid with gnt),
// peripherals drive fill/unload strobes synchronously, drum answers word strobes.
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module iodu_core #(
   parameter int RAND_CYC = iodu_pkg::RAND_START_CYC
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Core memory port
   output logic mem_req,
   output logic mem_we,
   output logic [11:0] mem_addr,
   output logic [23:0] mem_wdata,
   input wire logic [23:0] mem_rdata,
   input wire logic mem_gnt,
   // Address modification by the processor's index logic
   output logic [11:0] xr_base,
   input wire logic [11:0] xr_eff,
   // Sense and device select lines
   input wire logic [191:0] sense_lines,
   output logic [191:0] device_select_lines,
   output logic device_select_strobe,
   // Buffer register peripheral side
   input wire logic [7:0] ior_fill_stb,
   input wire logic [23:0] ior_fill_data,
   input wire logic [7:0] ior_unload_stb,
   output logic [23:0] ior_out_data,
   // Drum side
   output logic drum_req,
   output logic drum_we,
   output logic [22:0] drum_pos,
   output logic [23:0] drum_wdata,
   input wire logic [23:0] drum_rdata,
   input wire logic drum_ack,
   // Tape mode marks load/store as tape write/read
   input wire logic tape_mode
);
   typedef enum logic [3:0] {S_IDLE, S_FETCH, S_EXEC, S_WAIT_REG, S_MEM_WR, S_PAR1,
      S_PAR2, S_DELAY, S_DRUM_MEM, S_DRUM_XFER} iodu_state_t;

   // -------------------------------------------------------------------------
   // Sense line synchroniser, three stages
   // -------------------------------------------------------------------------
   logic [191:0] sense_s1_q, sense_s2_q, sense_s3_q, sense_stable_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sense_s1_q <= '0;
         sense_s2_q <= '0;
         sense_s3_q <= '0;
         sense_stable_q <= '0;
      end
      else
      begin
         sense_s1_q <= sense_lines;
         sense_s2_q <= sense_s1_q;
         sense_s3_q <= sense_s2_q;
         // A line changes only once stages two and three agree
         for (int i = 0; i < 192; i++)
            if (sense_s2_q[i] == sense_s3_q[i])
               sense_stable_q[i] <= sense_s3_q[i];
      end
   end

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   iodu_state_t st_q, st_d;
   iodu_pkg::iodu_instr_t ins_q, ins_d;
   logic [11:0] ea_q, ea_d;
   logic [23:0] left_acc_q, left_acc_d;
   logic [23:0] ior_q [8];
   logic [23:0] ior_d [8];
   logic [7:0] full_q, full_d;
   logic [191:0] dsel_q, dsel_d;
   logic dstb_q, dstb_d;
   logic [23:0] data_q, data_d;
   logic [11:0] cnt_q, cnt_d;
   logic [11:0] caddr_q, caddr_d;
   iodu_pkg::iodu_drum_pos_t dpos_q, dpos_d;
   logic rand_q, rand_d;
   logic [$clog2(RAND_CYC+1)-1:0] dly_q, dly_d;
   logic [6:0] lfsr_q;
   logic busy, start;
   logic [2:0] n;
   logic [5:0] op_hi;

   assign n = ins_q.opcode[2:0];
   assign op_hi = ins_q.opcode[8:3];
   assign busy = (st_q != S_IDLE);
   assign start = psel && penable && pwrite && (paddr == iodu_pkg::REG_INSTR) && !busy;
   assign xr_base = ins_q.operand;

   always_comb
   begin
      st_d = st_q;
      ins_d = ins_q;
      ea_d = ea_q;
      left_acc_d = left_acc_q;
      ior_d = ior_q;
      full_d = full_q;
      dsel_d = dsel_q;
      dstb_d = 1'b0;
      data_d = data_q;
      cnt_d = cnt_q;
      caddr_d = caddr_q;
      dpos_d = dpos_q;
      rand_d = rand_q;
      dly_d = dly_q;
      // Peripheral strobes keep the full flags current; a load or store completing on group n overrides its flag
      for (int i = 0; i < 8; i++)
      begin
         if (ior_fill_stb[i])
         begin
            ior_d[i] = ior_fill_data;
            full_d[i] = 1'b1;
         end
         if (ior_unload_stb[i])
            full_d[i] = 1'b0;
      end
      unique case (st_q)
         S_IDLE:
            if (start)
            begin
               ins_d = pwdata[21:0];
               st_d = S_FETCH;
            end
         S_FETCH:
         begin
            // Tape load/store use the raw operand
            if (ins_q.index_tag && !(tape_mode && (op_hi == iodu_pkg::OP_LOAD
                  || op_hi == iodu_pkg::OP_STORE)))
               ea_d = xr_eff;
            else
               ea_d = ins_q.operand;
            if (ins_q.opcode == iodu_pkg::OP_DRUM_WR || ins_q.opcode == iodu_pkg::OP_DRUM_RD)
               st_d = S_PAR1;
            else if (op_hi == iodu_pkg::OP_STORE || op_hi == iodu_pkg::OP_LOAD)
               st_d = S_WAIT_REG;
            else if (op_hi == iodu_pkg::OP_SENSE || op_hi == iodu_pkg::OP_SETUP)
               st_d = S_EXEC;
            else
               st_d = S_IDLE;
         end
         S_WAIT_REG:
            // Load waits for empty, store for full; no timeout by design
            if (op_hi == iodu_pkg::OP_LOAD && !full_q[n])
               st_d = S_EXEC;
            else if (op_hi == iodu_pkg::OP_STORE && full_q[n])
            begin
               data_d = ior_q[n];
               st_d = S_MEM_WR;
            end
         S_EXEC:
            if (mem_gnt)
            begin
               st_d = S_IDLE;
               if (op_hi == iodu_pkg::OP_SENSE)
                  left_acc_d = mem_rdata & sense_stable_q[n*24 +: 24];
               else if (op_hi == iodu_pkg::OP_SETUP)
               begin
                  dsel_d[n*24 +: 24] = mem_rdata;
                  dstb_d = 1'b1;
               end
               else
               begin
                  ior_d[n] = mem_rdata;
                  full_d[n] = 1'b1;
               end
            end
         S_MEM_WR:
            if (mem_gnt)
            begin
               full_d[n] = 1'b0;
               st_d = S_IDLE;
            end
         S_PAR1:
            if (mem_gnt)
            begin
               cnt_d = mem_rdata[23:iodu_pkg::CNT_LSB];
               caddr_d = mem_rdata[iodu_pkg::CNT_LSB-1:0];
               ea_d = ea_q + 12'h001;
               st_d = S_PAR2;
            end
         S_PAR2:
            if (mem_gnt)
            begin
               dpos_d.track = {mem_rdata[iodu_pkg::TRK_HI_B], mem_rdata[iodu_pkg::TRK_HI_A],
                  mem_rdata[12:iodu_pkg::TRK_LO_LSB]};
               dpos_d.buffer_area = mem_rdata[iodu_pkg::BUF_TRK_BIT];
               dpos_d.sector = mem_rdata[iodu_pkg::SEC_W-1:0];
               rand_d = mem_rdata[iodu_pkg::RAND_SEC_BIT] && ins_q.opcode == iodu_pkg::OP_DRUM_WR;
               dly_d = '0;
               if (cnt_q == 12'h000)
                  st_d = S_IDLE;
               else if (rand_d)
                  st_d = S_DELAY;
               else
                  st_d = (ins_q.opcode == iodu_pkg::OP_DRUM_WR) ? S_DRUM_MEM : S_DRUM_XFER;
            end
         S_DELAY:
            if (dly_q == ($clog2(RAND_CYC+1))'(RAND_CYC - 1))
            begin
               dpos_d.sector = lfsr_q;
               st_d = S_DRUM_MEM;
            end
            else
               dly_d = dly_q + 1'b1;
         S_DRUM_MEM:
            // Write: fetch word from core; read: put drum word into core
            if (mem_gnt)
            begin
               data_d = mem_rdata;
               if (ins_q.opcode == iodu_pkg::OP_DRUM_WR)
                  st_d = S_DRUM_XFER;
               else
               begin
                  caddr_d = caddr_q + 12'h001;
                  cnt_d = cnt_q - 12'h001;
                  st_d = (cnt_q == 12'h001) ? S_IDLE : S_DRUM_XFER;
               end
            end
         S_DRUM_XFER:
            if (drum_ack)
            begin
               dpos_d.sector = dpos_q.sector + 7'h01;
               if (ins_q.opcode == iodu_pkg::OP_DRUM_RD)
               begin
                  data_d = drum_rdata;
                  st_d = S_DRUM_MEM;
               end
               else
               begin
                  caddr_d = caddr_q + 12'h001;
                  cnt_d = cnt_q - 12'h001;
                  st_d = (cnt_q == 12'h001) ? S_IDLE : S_DRUM_MEM;
               end
            end
         default:
            st_d = S_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_q <= S_IDLE;
         ins_q <= '0;
         ea_q <= '0;
         left_acc_q <= '0;
         for (int i = 0; i < 8; i++)
            ior_q[i] <= '0;
         full_q <= '0;
         dsel_q <= '0;
         dstb_q <= 1'b0;
         data_q <= '0;
         cnt_q <= '0;
         caddr_q <= '0;
         dpos_q <= '0;
         rand_q <= 1'b0;
         dly_q <= '0;
         lfsr_q <= 7'h01;
      end
      else
      begin
         st_q <= st_d;
         ins_q <= ins_d;
         ea_q <= ea_d;
         left_acc_q <= left_acc_d;
         ior_q <= ior_d;
         full_q <= full_d;
         dsel_q <= dsel_d;
         dstb_q <= dstb_d;
         data_q <= data_d;
         cnt_q <= cnt_d;
         caddr_q <= caddr_d;
         dpos_q <= dpos_d;
         rand_q <= rand_d;
         dly_q <= dly_d;
         // Free-running source for the unknown start sector
         lfsr_q <= {lfsr_q[5:0], lfsr_q[6] ^ lfsr_q[5]};
      end
   end

   // -------------------------------------------------------------------------
   // Memory, drum and line outputs
   // -------------------------------------------------------------------------
   always_comb
   begin
      mem_req = 1'b0;
      mem_we = 1'b0;
      mem_addr = ea_q;
      mem_wdata = data_q;
      unique case (st_q)
         S_EXEC, S_PAR1, S_PAR2: mem_req = 1'b1;
         S_MEM_WR:
         begin
            mem_req = 1'b1;
            mem_we = 1'b1;
         end
         S_DRUM_MEM:
         begin
            mem_req = 1'b1;
            mem_we = (ins_q.opcode == iodu_pkg::OP_DRUM_RD);
            mem_addr = caddr_q;
         end
         default:
            mem_req = 1'b0;
      endcase
   end

   assign drum_req = (st_q == S_DRUM_XFER);
   assign drum_we = (ins_q.opcode == iodu_pkg::OP_DRUM_WR);
   assign drum_pos = {7'h00, dpos_q};
   assign drum_wdata = data_q;
   assign device_select_lines = dsel_q;
   assign device_select_strobe = dstb_q;
   assign ior_out_data = ior_q[0];

   // -------------------------------------------------------------------------
   // APB slave: zero wait states, unmapped address answers with error
   // -------------------------------------------------------------------------
   always_comb
   begin
      prdata = iodu_pkg::RESET_WORD;
      pslverr = 1'b0;
      unique case (paddr)
         iodu_pkg::REG_INSTR: prdata = {10'h000, ins_q};
         iodu_pkg::REG_STATUS: prdata = {20'h00000, cnt_q[7:0], st_q};
         iodu_pkg::REG_LEFT_ACC: prdata = {8'h00, left_acc_q};
         iodu_pkg::REG_DRUM_POS: prdata = {16'h0000, dpos_q};
         iodu_pkg::REG_FULL: prdata = {24'h000000, full_q};
         default: pslverr = psel && penable;
      endcase
   end
   assign pready = 1'b1;
endmodule
`default_nettype wire

// [testbench/iodu_far_model.sv]
// Far-side model: core memory with a grant handshake, and the drum.
// Assumes the unit holds every request steady until grant or ack.
`timescale 1ns/100ps
`default_nettype none
module iodu_far_model (
   // Clock, reset, pacing
   input wire logic pclk,
   input wire logic presetn,
   input wire logic slow,
   // Core memory
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [11:0] mem_addr,
   input wire logic [23:0] mem_wdata,
   output logic [23:0] mem_rdata,
   output logic mem_gnt,
   // Drum
   input wire logic drum_req,
   input wire logic drum_we,
   input wire logic [22:0] drum_pos,
   input wire logic [23:0] drum_wdata,
   output logic [23:0] drum_rdata,
   output logic drum_ack
);
   // Drum image indexed by buffer bit, track and sector
   logic [23:0] core_q [0:4095];
   logic [23:0] drum_q [0:65535];
   logic [2:0] mw_q, dw_q;
   always @(posedge pclk or negedge presetn)
      if (!presetn)
         {mem_gnt, drum_ack, mw_q, dw_q, mem_rdata, drum_rdata} <= '0;
      else
      begin
         // Data flips while not valid, so a stale word never passes
         mem_rdata <= ~mem_rdata;
         drum_rdata <= ~drum_rdata;
         mem_gnt <= 1'b0;
         drum_ack <= 1'b0;
         if (mem_gnt && mem_we)
            core_q[mem_addr] <= mem_wdata;
         if (drum_ack && drum_we)
            drum_q[drum_pos[15:0]] <= drum_wdata;
         if (mem_req && !mem_gnt)
            mw_q <= mw_q + 3'd1;
         if (mem_req && !mem_gnt && mw_q >= (slow ? 3'd3 : 3'd0))
         begin
            mem_gnt <= 1'b1;
            mw_q <= 3'd0;
            mem_rdata <= core_q[mem_addr];
         end
         if (drum_req && !drum_ack)
            dw_q <= dw_q + 3'd1;
         if (drum_req && !drum_ack && dw_q >= (slow ? 3'd5 : 3'd0))
         begin
            drum_ack <= 1'b1;
            dw_q <= 3'd0;
            drum_rdata <= drum_q[drum_pos[15:0]];
         end
      end
endmodule
`default_nettype wire

// [testbench/iodu_properties.sv]
// Checker for iodu_core: bus timing and data relations at its ports.
// Assumes it is bound into every iodu_core instance.
`timescale 1ns/100ps
`default_nettype none
module iodu_properties (
   // Clock, reset, APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   // Core memory and select lines
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [11:0] mem_addr,
   input wire logic [23:0] mem_wdata,
   input wire logic [23:0] mem_rdata,
   input wire logic mem_gnt,
   input wire logic [191:0] device_select_lines,
   input wire logic device_select_strobe,
   // Drum
   input wire logic drum_req,
   input wire logic drum_we,
   input wire logic [22:0] drum_pos,
   input wire logic [23:0] drum_wdata,
   input wire logic [23:0] drum_rdata,
   input wire logic drum_ack
);
   logic [23:0] rd_q, dq_q;
   logic [2:0] grp_q;
   logic pend_q;
   // Last memory read word, last drum word and group of the last instruction
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         {rd_q, dq_q, grp_q, pend_q} <= '0;
      else
      begin
         if (mem_gnt && !mem_we)
            rd_q <= mem_rdata;
         if (drum_ack && !drum_we)
            {dq_q, pend_q} <= {drum_rdata, 1'b1};
         else if (mem_gnt && mem_we)
            pend_q <= 1'b0;
         if (psel && penable && pwrite && paddr == 8'h00)
            grp_q <= pwdata[15:13];
      end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence apb_acc;
      psel && penable;
   endsequence
   sequence mem_wait;
      mem_req && !mem_gnt;
   endsequence
   zero_wait_a: assert property (apb_acc |-> pready) else $error("pready low");
   unmapped_err_a: assert property ((apb_acc and !(paddr inside {8'h00, 8'h04, 8'h08,
      8'h0C, 8'h10})) |-> pslverr) else $error("no error on unmapped address");
   select_mask_a: assert property (device_select_strobe |->
      device_select_lines[grp_q*24 +: 24] == rd_q) else $error("select group not the mask");
   select_only_a: assert property ($changed(device_select_lines) |->
      device_select_strobe) else $error("select lines moved without strobe");
   strobe_pulse_a: assert property (device_select_strobe |=> !device_select_strobe)
      else $error("strobe longer than one cycle");
   mem_hold_a: assert property (mem_wait |=> mem_req && $stable({mem_we, mem_addr}))
      else $error("memory request dropped or changed");
   drum_hold_a: assert property (drum_req && !drum_ack |=> drum_req
      && $stable({drum_we, drum_pos})) else $error("drum request dropped or changed");
   drum_wdata_a: assert property (drum_req && drum_we |-> drum_wdata == rd_q)
      else $error("drum write word not the core word");
   drum_core_a: assert property (mem_req && mem_we && pend_q |-> mem_wdata == dq_q)
      else $error("core write word not the drum word");
   reset_idle_a: assert property ($rose(presetn) |-> !mem_req && !drum_req)
      else $error("request active after reset");
endmodule
bind iodu_core iodu_properties chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
   .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_gnt(mem_gnt),
   .device_select_lines(device_select_lines), .device_select_strobe(device_select_strobe),
   .drum_req(drum_req), .drum_we(drum_we), .drum_pos(drum_pos), .drum_wdata(drum_wdata),
   .drum_rdata(drum_rdata), .drum_ack(drum_ack));
`default_nettype wire

// [testbench/io_instruction_drum_unit_tb.sv]
// Bench for iodu_core: instructions issued over APB, results compared.
// Assumes iodu_far_model for memory and drum; index logic subtracts 5.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
   $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end
module io_instruction_drum_unit_tb;
   localparam int RC = 60;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, fill_stb = 8'h00, unl_stb = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, mem_req, mem_we, mem_gnt, dsel_stb, drum_req, drum_we, drum_ack;
   logic [11:0] mem_addr, xr_base, xr_eff;
   logic [23:0] mem_wdata, mem_rdata, ior_out, drum_wdata, drum_rdata, m;
   logic [23:0] fill_data = 24'h0;
   logic [191:0] sense = '0, dsel, exp_sel;
   logic [22:0] drum_pos;
   logic tape_mode = 1'b0, slow = 1'b0, err;
   int n_errors = 0, num_checks = 0, cyc = 0, t0, n, k;
   always #20 pclk = ~pclk;
   always @(posedge pclk) cyc <= cyc + 1;
   assign xr_eff = xr_base - 12'h005;
   iodu_core #(.RAND_CYC(RC)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_gnt(mem_gnt),
      .xr_base(xr_base), .xr_eff(xr_eff), .sense_lines(sense), .device_select_lines(dsel),
      .device_select_strobe(dsel_stb), .ior_fill_stb(fill_stb), .ior_fill_data(fill_data),
      .ior_unload_stb(unl_stb), .ior_out_data(ior_out), .drum_req(drum_req),
      .drum_we(drum_we), .drum_pos(drum_pos), .drum_wdata(drum_wdata),
      .drum_rdata(drum_rdata), .drum_ack(drum_ack), .tape_mode(tape_mode));
   iodu_far_model far_u (.pclk(pclk), .presetn(presetn), .slow(slow), .mem_req(mem_req),
      .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .mem_gnt(mem_gnt), .drum_req(drum_req), .drum_we(drum_we), .drum_pos(drum_pos),
      .drum_wdata(drum_wdata), .drum_rdata(drum_rdata), .drum_ack(drum_ack));
   task automatic print_verdict();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rd, e)
   endtask
   task automatic issue(input logic [8:0] op, input logic tag, input logic [11:0] y);
      apb(1'b1, iodu_pkg::REG_INSTR, {10'h0, op, tag, y});
   endtask
   // Polls status; the watchdog catches a unit that never goes idle
   // A write while busy is dropped, so the unit must be idle before issue
   task automatic run(input logic [8:0] op, input logic tag, input logic [11:0] y);
      do apb(1'b0, iodu_pkg::REG_STATUS, 32'h0); while (rd[3:0] !== 4'h0);
      issue(op, tag, y);
      do apb(1'b0, iodu_pkg::REG_STATUS, 32'h0); while (rd[3:0] !== 4'h0);
   endtask
   task automatic stalled();
      repeat (10) @(posedge pclk);
      apb(1'b0, iodu_pkg::REG_STATUS, 32'h0);
      `CHK(rd[3:0] != 4'h0, 1'b1)
   endtask
   task automatic pulse(input logic f, input int i, input logic [23:0] d);
      @(posedge pclk);
      fill_stb[i] <= f;
      unl_stb[i] <= !f;
      fill_data <= d;
      @(posedge pclk);
      {fill_stb, unl_stb} <= 16'h0000;
   endtask
   function automatic logic [23:0] dw2(input logic b, input logic [7:0] t,
      input logic [6:0] s, input logic r);
      dw2 = {7'h00, t[7], r, b, t[6], t[5:0], s};
   endfunction
   initial
   begin
      for (n = 0; n < 8; n++)
         sense[n*24 +: 24] = 24'h3C96A5 ^ {8{3'(n)}};
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      chk_reg(iodu_pkg::REG_LEFT_ACC, 32'h0);
      chk_reg(iodu_pkg::REG_FULL, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      `CHK(err, 1'b1)
      for (n = 0; n < 8; n++)
      begin
         m = 24'hF00FF0 ^ {3{8'(n * 37)}};
         exp_sel[n*24 +: 24] = m;
         far_u.core_q[12'h100 + n] = m;
         run({iodu_pkg::OP_SENSE, 3'(n)}, 1'b0, 12'h100 + 12'(n));
         chk_reg(iodu_pkg::REG_LEFT_ACC, {8'h0, m & sense[n*24 +: 24]});
         run({iodu_pkg::OP_SETUP, 3'(n)}, 1'b0, 12'h100 + 12'(n));
      end
      `CHK(dsel, exp_sel)
      far_u.core_q[12'h1FB] = 24'h00FFFF;
      far_u.core_q[12'h200] = 24'hFF0000;
      run({iodu_pkg::OP_SENSE, 3'd0}, 1'b1, 12'h200);
      chk_reg(iodu_pkg::REG_LEFT_ACC, {8'h0, 24'h00FFFF & sense[23:0]});
      pulse(1'b1, 3, 24'h111111);
      chk_reg(iodu_pkg::REG_FULL, 32'h8);
      far_u.core_q[12'h300] = 24'hABCDEF;
      issue({iodu_pkg::OP_LOAD, 3'd3}, 1'b0, 12'h300);
      stalled();
      pulse(1'b0, 3, 24'h0);
      run({iodu_pkg::OP_STORE, 3'd3}, 1'b0, 12'h301);
      `CHK(far_u.core_q[12'h301], 24'hABCDEF)
      chk_reg(iodu_pkg::REG_FULL, 32'h0);
      issue({iodu_pkg::OP_STORE, 3'd2}, 1'b0, 12'h302);
      stalled();
      pulse(1'b1, 2, 24'h5A5A5A);
      run({iodu_pkg::OP_SETUP, 3'd1}, 1'b0, 12'h101);
      `CHK(far_u.core_q[12'h302], 24'h5A5A5A)
      tape_mode <= 1'b1;
      far_u.core_q[12'h310] = 24'h13579B;
      far_u.core_q[12'h30B] = 24'h2468AC;
      run({iodu_pkg::OP_LOAD, 3'd0}, 1'b1, 12'h310);
      `CHK(ior_out, 24'h13579B)
      tape_mode <= 1'b0;
      run({iodu_pkg::OP_SETUP, 3'd0}, 1'b0, 12'h100);
      `CHK(dsel[23:0], exp_sel[23:0])
      `CHK(ior_out, 24'h13579B)
      // Sector 126 start checks the wrap past 127
      far_u.core_q[12'h400] = {12'd3, 12'h500};
      far_u.core_q[12'h401] = dw2(1'b0, 8'o224, 7'd126, 1'b0);
      for (n = 0; n < 3; n++)
         far_u.core_q[12'h500 + n] = 24'hC00000 + 24'(n);
      run(iodu_pkg::OP_DRUM_WR, 1'b0, 12'h400);
      for (n = 0; n < 3; n++)
         `CHK(far_u.drum_q[{1'b0, 8'o224, 7'(126 + n)}], 24'hC00000 + 24'(n))
      slow <= 1'b1;
      for (n = 0; n < 2; n++)
         far_u.drum_q[{1'b1, 8'd7, 7'(16 + n)}] = 24'hD00000 + 24'(n);
      far_u.core_q[12'h410] = {12'd2, 12'h520};
      far_u.core_q[12'h411] = dw2(1'b1, 8'd7, 7'd16, 1'b1);
      run(iodu_pkg::OP_DRUM_RD, 1'b0, 12'h410);
      for (n = 0; n < 2; n++)
         `CHK(far_u.core_q[12'h520 + n], 24'hD00000 + 24'(n))
      slow <= 1'b0;
      far_u.core_q[12'h420] = {12'd1, 12'h530};
      far_u.core_q[12'h421] = dw2(1'b0, 8'd5, 7'd0, 1'b1);
      far_u.core_q[12'h530] = 24'hE1E1E1;
      t0 = cyc;
      run(iodu_pkg::OP_DRUM_WR, 1'b0, 12'h420);
      `CHK(cyc - t0 > RC, 1'b1)
      k = 0;
      for (n = 0; n < 128; n++)
         k += (far_u.drum_q[{1'b0, 8'd5, 7'(n)}] === 24'hE1E1E1);
      `CHK(k, 1)
      print_verdict();
   end
   initial
   begin
      repeat (40000) @(posedge pclk);
      n_errors++;
      print_verdict();
   end
endmodule
`default_nettype wire
